/* bench/enc_ctrl_model.sv */
// drive-controller model that frames commands for the decoder
`default_nettype none
module enc_ctrl_model
  import enc_cmd_pkg::*;
(
  // clock
  input wire logic clk,
  // frame out
  output logic frame_valid,
  output frame_t frame,
  // reply in
  input wire logic reply_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] code_now; // protection code as the controller knows it
  // idle link at start, shipped code assumed
  initial begin
    frame_valid = 1'b0;
    frame = '0;
    code_now = ACCESS_CODE_RESET;
  end
  // one frame, then a bounded wait for the reply pulse
  task automatic send(input logic [7:0] c, input logic [3:0] nb,
    input logic [7:0] a0, input logic [7:0] a1, input logic pe,
    input logic ce, output logic got);
    frame_t f;
    f = '{c, nb, a0, a1, pe, ce};
    @(posedge clk);
    frame_valid <= 1'b1;
    frame <= f;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame <= ~f; // released frame shows no stale data
    got = 1'b0;
    for (int n = 0; n < 4 && !got; n++) begin
      @(negedge clk);
      got = (reply_valid === 1'b1);
    end
  endtask : send
  // guarded command: protection byte inserted in arg0
  task automatic send_guarded(input logic [7:0] c, input logic [7:0] a1,
    input logic bad, output logic got);
    send(c, 4'h2, bad ? ~code_now : code_now, a1, 1'b0, 1'b0, got);
    if (!bad && c == CMD_CHANGE_CODE) begin
      code_now = a1;
    end
  endtask : send_guarded
endmodule : enc_ctrl_model
`default_nettype wire

/* bench/encoder_command_status_decoder_tb.sv */
// self-checking bench for the command decoder and status reporter
`default_nettype none
module encoder_command_status_decoder_tb
  import enc_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, frame_valid, cmd_valid, cfg_write, reply_valid, got;
  frame_t frame;
  fault_t faults;
  op_t cmd_op;
  logic [7:0] cmd_arg, reply_status, status, access_code;
  int fail_count, samples_checked;

  enc_ctrl_model i_enc_ctrl_model (.clk(clk), .frame_valid(frame_valid),
    .frame(frame), .reply_valid(reply_valid));
  enc_cmd_status i_enc_cmd_status (.clk(clk), .reset_n(reset_n),
    .frame_valid(frame_valid), .frame(frame), .faults(faults),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cfg_write(cfg_write),
    .cmd_arg(cmd_arg), .reply_valid(reply_valid),
    .reply_status(reply_status), .status(status),
    .access_code(access_code));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // a lost reply ends the run
  task automatic arrived();
    if (got !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask : arrived
  task automatic tx(input logic [7:0] c, input logic [3:0] nb,
    input logic [7:0] a0, input logic [7:0] a1, input logic pe,
    input logic ce);
    i_enc_ctrl_model.send(c, nb, a0, a1, pe, ce, got);
    arrived();
  endtask : tx
  task automatic gtx(input logic [7:0] c, input logic [7:0] a1,
    input logic bad);
    i_enc_ctrl_model.send_guarded(c, a1, bad, got);
    arrived();
  endtask : gtx
  task automatic clear_status();
    tx(CMD_RESET, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    check("status", status, ST_OK);
  endtask : clear_status

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    check("status", status, ST_OK);
    check("access_code", access_code, ACCESS_CODE_RESET);
  endtask : test_reset
  // every ordinary command: {cmd, length, op}
  task automatic test_commands();
    logic [15:0] t [14] = '{16'h4201, 16'h4342, 16'h4413, 16'h4604,
      16'h4705, 16'h4916, 16'h4A27, 16'h4B28, 16'h4C19, 16'h4D2A,
      16'h4E0B, 16'h500D, 16'h530E, 16'h560F};
    for (int i = 0; i < 14; i++) begin
      tx(t[i][15:8], t[i][7:4], t[i][15:8] == CMD_READ_ANALOG ?
        ANALOG_TEMP_CHAN : 8'h00, 8'(i + 1), 1'b0, 1'b0);
      check("cmd_valid", {7'h00, cmd_valid}, 8'h01);
      check("cmd_op", {4'h0, cmd_op}, {4'h0, t[i][3:0]});
      check("cmd_arg", cmd_arg, 8'(i + 1));
      check("reply_status", reply_status, ST_OK);
    end
  endtask : test_commands
  // frame errors by priority: {cmd, nbytes, pe ce, arg0, code}
  task automatic test_proto();
    logic [31:0] t [5] = '{32'h4503_0009, 32'h4501_000A, 32'h4500_000B,
      32'h4210_000C, 32'h4410_470D};
    for (int i = 0; i < 5; i++) begin
      tx(t[i][31:24], t[i][23:20], t[i][15:8], 8'h00, t[i][17], t[i][16]);
      check("cmd_valid", {7'h00, cmd_valid}, 8'h00);
      check("reply_status", reply_status, t[i][7:0]);
      check("status", status, t[i][7:0]);
      tx(CMD_READ_STATUS, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0);
      check("held status", reply_status, t[i][7:0]);
      check("status", status, ST_OK);
    end
  endtask : test_proto
  task automatic test_guard();
    gtx(CMD_CONFIG_IF, 8'h3C, 1'b0);
    check("cfg_write", {7'h00, cfg_write}, 8'h01);
    check("cmd_valid", {7'h00, cmd_valid}, 8'h00);
    check("cmd_op", {4'h0, cmd_op}, {4'h0, OP_NONE});
    gtx(CMD_CONFIG_IF, 8'h3C, 1'b1);
    check("cfg_write", {7'h00, cfg_write}, 8'h00);
    check("reply_status", reply_status, ST_BAD_CODE);
    gtx(CMD_CHANGE_CODE, 8'hA7, 1'b0);
    check("access_code", access_code, 8'hA7);
    tx(CMD_CONFIG_IF, 4'h2, 8'h55, 8'h3C, 1'b0, 1'b0);
    check("status", status, ST_BAD_CODE);
    gtx(CMD_CONFIG_IF, 8'h3C, 1'b0);
    check("cfg_write", {7'h00, cfg_write}, 8'h01);
    clear_status();
  endtask : test_guard
  // data-field faults: {cmd, code}, flags wprot down to no_field
  task automatic test_fields();
    logic [15:0] t [4] = '{16'h4B0E, 16'h4D10, 16'h4A11, 16'h4A12};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      faults <= fault_t'(14'(4'h8 >> i));
      tx(t[i][15:8], 4'h2, 8'h00, 8'h00, 1'b0, 1'b0);
      check("cmd_valid", {7'h00, cmd_valid}, 8'h00);
      check("reply_status", reply_status, t[i][7:0]);
      @(posedge clk);
      faults <= '0;
      clear_status();
    end
  endtask : test_fields
  // core faults: {fault bits, code}
  task automatic test_core();
    logic [23:0] t [15] = '{24'h080001, 24'h100002, 24'h180003,
      24'h200004, 24'h280005, 24'h300006, 24'h380007, 24'h04001C,
      24'h02001D, 24'h01001E, 24'h00801F, 24'h004020, 24'h001021,
      24'h002022, 24'h003023};
    for (int i = 0; i < 15; i++) begin
      @(posedge clk);
      faults <= fault_t'(t[i][21:8]);
      @(posedge clk);
      @(negedge clk);
      check("status", status, t[i][7:0]);
      @(posedge clk);
      faults <= '0;
      clear_status();
    end
  endtask : test_core
  task automatic test_overflow();
    tx(CMD_CLR_CNT, 4'h1, 8'h00, 8'h00, 1'b0, 1'b0);
    repeat (255) tx(CMD_INC_CNT, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    check("status", status, ST_OK);
    tx(CMD_INC_CNT, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    check("status", status, ST_CNT_OVF);
    clear_status();
  endtask : test_overflow

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // reset, then the scenarios
  initial begin
    reset_n = 1'b0;
    faults = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    test_reset();
    test_commands();
    test_proto();
    test_guard();
    test_fields();
    test_core();
    test_overflow();
    give_verdict();
  end
endmodule : encoder_command_status_decoder_tb
`default_nettype wire

/* rtl/enc_cmd_lookup.sv */
// command byte lookup: operation, expected length and protection flag
`default_nettype none
module enc_cmd_lookup
  import enc_cmd_pkg::*;
(
  // command in
  input wire logic [7:0] cmd,
  // decode out
  output logic known,
  output logic guarded,
  output logic [3:0] length,
  output op_t op
);
  // ---------------------------------------------------------------
  // table
  // ---------------------------------------------------------------
  // one row per decoded command
  always_comb begin
    known = 1'b1;
    guarded = 1'b0;
    length = 4'h0;
    op = OP_NONE;
    unique case (cmd)
      CMD_READ_POS: op = OP_READ_POS; // R1
      CMD_SET_POS: begin
        op = OP_SET_POS;
        length = 4'h4;
      end
      CMD_READ_ANALOG: begin
        op = OP_READ_ANALOG;
        length = 4'h1;
      end
      CMD_READ_STATUS: op = OP_READ_STATUS;
      CMD_RESET: op = OP_RESET;
      CMD_SERIAL: op = OP_SERIAL;
      CMD_READ_CNT: op = OP_READ_CNT; // R2
      CMD_INC_CNT: op = OP_INC_CNT;
      CMD_CLR_CNT: begin
        op = OP_CLR_CNT;
        length = 4'h1;
      end
      CMD_READ_DATA: begin
        op = OP_READ_DATA;
        length = 4'h2;
      end
      CMD_STORE_DATA: begin
        op = OP_STORE_DATA;
        length = 4'h2;
      end
      CMD_FIELD_STAT: begin
        op = OP_FIELD_STAT;
        length = 4'h1;
      end
      CMD_CREATE_FIELD: begin
        op = OP_CREATE_FIELD;
        length = 4'h2;
      end
      CMD_FREE_MEM: op = OP_FREE_MEM;
      CMD_CHANGE_CODE: begin
        op = OP_CHANGE_CODE;
        length = 4'h2;
      end
      CMD_CONFIG_IF: begin
        op = OP_NONE;
        guarded = 1'b1; // R3
        length = 4'h2;
      end
      default: known = 1'b0;
    endcase
  end
endmodule : enc_cmd_lookup
`default_nettype wire

/* rtl/enc_cmd_pkg.sv */
// constants and types shared by the command decoder and its checker
`default_nettype none
package enc_cmd_pkg;
  // ---------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_POS = 8'h42;
  localparam logic [7:0] CMD_SET_POS = 8'h43;
  localparam logic [7:0] CMD_READ_ANALOG = 8'h44;
  localparam logic [7:0] CMD_READ_CNT = 8'h46;
  localparam logic [7:0] CMD_INC_CNT = 8'h47;
  localparam logic [7:0] CMD_CLR_CNT = 8'h49;
  localparam logic [7:0] CMD_READ_DATA = 8'h4A;
  localparam logic [7:0] CMD_STORE_DATA = 8'h4B;
  localparam logic [7:0] CMD_FIELD_STAT = 8'h4C;
  localparam logic [7:0] CMD_CREATE_FIELD = 8'h4D;
  localparam logic [7:0] CMD_FREE_MEM = 8'h4E;
  localparam logic [7:0] CMD_CHANGE_CODE = 8'h4F;
  localparam logic [7:0] CMD_READ_STATUS = 8'h50;
  localparam logic [7:0] CMD_RESET = 8'h53;
  localparam logic [7:0] CMD_SERIAL = 8'h56;
  localparam logic [7:0] CMD_CONFIG_IF = 8'h57;
  localparam logic [7:0] ANALOG_TEMP_CHAN = 8'h48;
  localparam logic [7:0] ACCESS_CODE_RESET = 8'h55;
  // ---------------------------------------------------------------
  // status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_INIT_FIRST = 8'h01;
  localparam logic [7:0] ST_INIT_LAST = 8'h07;
  localparam logic [7:0] ST_CNT_OVF = 8'h08;
  localparam logic [7:0] ST_PARITY = 8'h09;
  localparam logic [7:0] ST_CHECKSUM = 8'h0A;
  localparam logic [7:0] ST_UNKNOWN_CMD = 8'h0B;
  localparam logic [7:0] ST_LENGTH = 8'h0C;
  localparam logic [7:0] ST_BAD_ARG = 8'h0D;
  localparam logic [7:0] ST_WRITE_PROT = 8'h0E;
  localparam logic [7:0] ST_BAD_CODE = 8'h0F;
  localparam logic [7:0] ST_SIZE_FIXED = 8'h10;
  localparam logic [7:0] ST_ADDR_RANGE = 8'h11;
  localparam logic [7:0] ST_NO_FIELD = 8'h12;
  localparam logic [7:0] ST_ANALOG_MON = 8'h1C;
  localparam logic [7:0] ST_TX_CURRENT = 8'h1D;
  localparam logic [7:0] ST_TEMP = 8'h1E;
  localparam logic [7:0] ST_SPEED = 8'h1F;
  localparam logic [7:0] ST_SINGLETURN = 8'h20;
  localparam logic [7:0] ST_MT_FIRST = 8'h21;
  localparam logic [7:0] ST_MT_LAST = 8'h23;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cmd;        // command byte
    logic [3:0] nbytes;     // data bytes received after the command
    logic [7:0] arg0;       // first data byte
    logic [7:0] arg1;       // second data byte
    logic parity_err;       // parity fault seen in the frame
    logic checksum_err;     // frame checksum mismatch
  } frame_t;
  typedef struct packed {
    logic [2:0] init_code;  // 0 none, else init fault 1..7
    logic analog_mon;
    logic tx_current;
    logic temp_crit;
    logic overspeed;
    logic singleturn;
    logic [1:0] multiturn;  // 0 none, else 21h..23h
    logic wprot;            // addressed field write protected
    logic size_fixed;
    logic addr_range;
    logic no_field;
  } fault_t;
  typedef enum logic [3:0] {
    OP_NONE, OP_READ_POS, OP_SET_POS, OP_READ_ANALOG, OP_READ_CNT,
    OP_INC_CNT, OP_CLR_CNT, OP_READ_DATA, OP_STORE_DATA, OP_FIELD_STAT,
    OP_CREATE_FIELD, OP_FREE_MEM, OP_CHANGE_CODE, OP_READ_STATUS,
    OP_RESET, OP_SERIAL
  } op_t;
  localparam logic [3:0] OP_CONFIG_CODE = 4'hF;
endpackage : enc_cmd_pkg
`default_nettype wire

/* rtl/enc_cmd_status.sv */
// parameter-channel command decoder and status reporter
// What this block does
// R1: decode position, analog, status, reset, serial commands
// R2: decode counter and data-field commands
// R3: guarded commands checked against protection byte
// R4: access code resets to 55h, 4Fh changes
// R5: no fault gives status 00h
// R6: init faults report 01h to 07h
// R7: parity 09h, checksum 0Ah, unknown 0Bh
// R8: wrong data byte count reports 0Ch
// R9: disallowed argument reports 0Dh
// R10: write protect 0Eh, wrong code 0Fh
// R11: field size 10h, range 11h, missing 12h
// R12: speed 1Fh, singleturn 20h, multiturn 21h-23h
// R13: analog 1Ch, current 1Dh, temp 1Eh, overflow 08h
// R14: latest fault held, returned on status read
`default_nettype none
module enc_cmd_status
  import enc_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // received frame
  input wire logic frame_valid,
  input wire frame_t frame,
  // fault sources from the encoder core
  input wire fault_t faults,
  // decoded command out
  output logic cmd_valid,
  output op_t cmd_op,
  output logic cfg_write,
  output logic [7:0] cmd_arg,
  // reply
  output logic reply_valid,
  output logic [7:0] reply_status,
  output logic [7:0] status,
  output logic [7:0] access_code
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic known;
  logic guarded;
  logic [3:0] length;
  op_t op;
  enc_cmd_lookup i_enc_cmd_lookup (
    .cmd(frame.cmd),
    .known(known),
    .guarded(guarded),
    .length(length),
    .op(op)
  );

  // guarded commands carry the code as their first data byte
  function automatic logic code_needed(input logic [7:0] c);
    code_needed = (c == CMD_CONFIG_IF) || (c == CMD_CHANGE_CODE);
  endfunction : code_needed

  // ---------------------------------------------------------------
  // frame status, first match wins
  // ---------------------------------------------------------------
  logic [7:0] frame_err;
  logic frame_ok;
  always_comb begin
    frame_err = ST_OK;
    if (frame.parity_err)
      frame_err = ST_PARITY; // R7
    else if (frame.checksum_err)
      frame_err = ST_CHECKSUM; // R7
    else if (!known)
      frame_err = ST_UNKNOWN_CMD; // R7
    else if (frame.nbytes != length)
      frame_err = ST_LENGTH; // R8
    else if (code_needed(frame.cmd) && frame.arg0 != access_code)
      frame_err = ST_BAD_CODE; // R3 R10
    else if (op == OP_READ_ANALOG && frame.arg0 != ANALOG_TEMP_CHAN)
      frame_err = ST_BAD_ARG; // R9
    else if (op == OP_STORE_DATA && faults.wprot)
      frame_err = ST_WRITE_PROT; // R10
    else if (op == OP_CREATE_FIELD && faults.size_fixed)
      frame_err = ST_SIZE_FIXED; // R11
    else if ((op == OP_READ_DATA || op == OP_STORE_DATA)
             && faults.addr_range)
      frame_err = ST_ADDR_RANGE; // R11
    else if ((op == OP_READ_DATA || op == OP_STORE_DATA ||
              op == OP_FIELD_STAT) && faults.no_field)
      frame_err = ST_NO_FIELD; // R11
    frame_ok = (frame_err == ST_OK);
  end

  // ---------------------------------------------------------------
  // standing faults of the encoder core
  // ---------------------------------------------------------------
  logic [7:0] core_err;
  always_comb begin
    core_err = ST_OK; // R5
    if (faults.init_code != 3'h0)
      core_err = ST_INIT_FIRST + {5'h00, faults.init_code} - 8'h01; // R6
    else if (faults.overspeed)
      core_err = ST_SPEED; // R12
    else if (faults.singleturn)
      core_err = ST_SINGLETURN; // R12
    else if (faults.multiturn != 2'h0)
      core_err = ST_MT_FIRST + {6'h00, faults.multiturn} - 8'h01; // R12
    else if (faults.analog_mon)
      core_err = ST_ANALOG_MON; // R13
    else if (faults.tx_current)
      core_err = ST_TX_CURRENT; // R13
    else if (faults.temp_crit)
      core_err = ST_TEMP; // R13
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic next_cmd_valid;
  op_t next_cmd_op;
  logic next_cfg_write;
  logic [7:0] next_cmd_arg;
  logic next_reply_valid;
  logic [7:0] next_reply_status;
  logic [7:0] next_status;
  logic [7:0] next_access_code;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  always_comb begin
    next_cmd_valid = 1'b0;
    next_cmd_op = OP_NONE;
    next_cfg_write = 1'b0;
    next_cmd_arg = cmd_arg;
    next_reply_valid = 1'b0;
    next_reply_status = reply_status;
    next_status = status;
    next_access_code = access_code;
    next_cnt = cnt;
    // core faults latch as the latest fault
    if (core_err != ST_OK)
      next_status = core_err; // R14
    if (frame_valid) begin
      next_reply_valid = 1'b1;
      if (!frame_ok) begin
        next_status = frame_err; // R14
        next_reply_status = frame_err;
      end else begin
        next_cmd_valid = !guarded;
        next_cmd_op = op; // R1 R2
        next_cfg_write = guarded; // R3
        next_cmd_arg = frame.arg1;
        next_reply_status = status; // R14
        unique case (op)
          OP_CHANGE_CODE: next_access_code = frame.arg1; // R4
          OP_INC_CNT: begin
            if (cnt == 8'hFF)
              next_status = ST_CNT_OVF; // R13
            else
              next_cnt = cnt + 8'h01;
          end
          OP_CLR_CNT: next_cnt = 8'h00;
          // a standing core fault wins over the clear
          OP_READ_STATUS: next_status = core_err; // R5 R14
          OP_RESET: next_status = core_err; // R5
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid <= 1'b0;
      cmd_op <= OP_NONE;
      cfg_write <= 1'b0;
      cmd_arg <= 8'h00;
      reply_valid <= 1'b0;
      reply_status <= ST_OK;
      status <= ST_OK;
      access_code <= ACCESS_CODE_RESET; // R4
      cnt <= 8'h00;
    end else begin
      cmd_valid <= next_cmd_valid;
      cmd_op <= next_cmd_op;
      cfg_write <= next_cfg_write;
      cmd_arg <= next_cmd_arg;
      reply_valid <= next_reply_valid;
      reply_status <= next_reply_status;
      status <= next_status;
      access_code <= next_access_code;
      cnt <= next_cnt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  unknown_cmd_a: assert property ( // R7
    frame_valid && !frame.parity_err && !frame.checksum_err && !known
    |=> status == ST_UNKNOWN_CMD && reply_valid)
    else $error("unknown command not flagged");
  parity_flag_a: assert property ( // R7
    frame_valid && frame.parity_err |=> reply_status == ST_PARITY)
    else $error("parity fault not flagged");
  guard_code_a: assert property ( // R3
    frame_valid && frame.cmd == CMD_CONFIG_IF && !frame.parity_err
    && !frame.checksum_err && frame.nbytes == 4'h2
    && frame.arg0 != access_code |=> status == ST_BAD_CODE && !cfg_write)
    else $error("guarded command ran with wrong code");
  length_check_a: assert property ( // R8
    frame_valid && !frame.parity_err && !frame.checksum_err && known
    && frame.nbytes != length |=> status == ST_LENGTH && !cmd_valid)
    else $error("length fault not flagged");
  code_change_a: assert property ( // R4
    cmd_valid && cmd_op == OP_CHANGE_CODE |-> access_code == cmd_arg)
    else $error("access code not updated");
  bad_arg_a: assert property ( // R9
    frame_valid && frame_err == ST_BAD_ARG |=> status == ST_BAD_ARG)
    else $error("bad argument not flagged");
  temp_fault_a: assert property ( // R13
    !frame_valid && faults == fault_t'({3'h0, 3'b001, 8'h00})
    |=> status == ST_TEMP)
    else $error("temperature fault not held");
  status_hold_a: assert property ( // R14
    !frame_valid && core_err == ST_OK |=> $stable(status))
    else $error("status changed without cause");
  clear_read_a: assert property ( // R5
    frame_valid && frame_ok && op == OP_READ_STATUS && core_err == ST_OK
    |=> status == ST_OK && reply_status == $past(status))
    else $error("status not cleared by read");

  cmd_run_c: cover property (cmd_valid && cmd_op == OP_SET_POS);
  cfg_run_c: cover property (cfg_write);
  overflow_c: cover property (status == ST_CNT_OVF);
  init_fault_c: cover property (status == ST_INIT_LAST);
endmodule : enc_cmd_status
`default_nettype wire
